// File: verilog/frt_timer.v
// free running 16-bit timer: four captures, two compares, apb slave
// assumes apb master on clk; pins asynchronous; power mode low holds reset
// Functional notes
// [RQ1] per channel edge select, 1 is rising
// [RQ2] capture delayed one clock during high read
// [RQ3] buffer mode: c/d buffer a/b
// [RQ4] buffer pin edge sets flag only
// [RQ5] buffered capture delayed if pair read
// [RQ6] flag and capture register update together
// [RQ7] compare match when counter leaves matching value
// [RQ8] wrap flag on ffff to zero
// [RQ9] registers held reset outside active/sleep
// [RQ10] seven sources, each gated by enable
// [RQ11] one shared request, separate flags
// [RQ12] clear beats counter write
// [RQ13] counter write beats increment
// [RQ14] compare write suppresses that match
// [RQ15] internal count on divided falling edge
// [RQ16] source switch may add one count
// [RQ17] software toggles levels for 50% pulses
// [RQ18] clock select div2/8/32/external, div2 reset
// [RQ19] outputs take level on match, reset 0
// [RQ20] clear on match a zeroes counter
// [RQ21] software accesses high byte then low; the code moves the whole word in one 32-bit access
// [RQ22] capture pins synchronised before edge detect
`timescale 1ns/1ns
`include "frt_defs.vh"
module frt_timer #(
	parameter DIV_W = 5
) (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// power mode: high in active or sleep
	input  wire        run_mode,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// pins
	input  wire [3:0]  capture_pin,
	input  wire        ext_clk_pin,
	output reg         compare_out_pin_a,
	output reg         compare_out_pin_b,
	// shared interrupt request
	output reg         timer_irq
);
	wire live = rst_n & run_mode; // [RQ9]
	reg  [15:0] free_running_counter;
	reg  [15:0] compare_reg_a;
	reg  [15:0] compare_reg_b;
	reg  [15:0] capture_reg_a;
	reg  [15:0] capture_reg_b;
	reg  [15:0] capture_reg_c;
	reg  [15:0] capture_reg_d;
	reg  [6:0]  timer_irq_enable_reg;
	reg  [7:0]  timer_control_reg;
	reg  [1:0]  compare_output_control_reg;
	reg  [7:0]  timer_status_control_reg;
	reg  [DIV_W-1:0] prescale;
	reg  [3:0]  cap_pend;
	reg         int_prev;
	reg         ext_prev;
	reg         cmpa_hold;
	reg         cmpb_hold;
	wire [3:0]  cap_rise;
	wire [3:0]  cap_fall;
	wire [3:0]  cap_lvl;
	wire        ext_lvl;
	wire        ext_rise_unused;
	wire        ext_fall_unused;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_sync
			frt_sync u_sync ( // [RQ22]
				.clk   (clk),
				.rst_n (live),
				.pin   (capture_pin[g]),
				.level (cap_lvl[g]),
				.rise  (cap_rise[g]),
				.fall  (cap_fall[g])
			);
		end
	endgenerate
	frt_sync u_ext (
		.clk   (clk),
		.rst_n (live),
		.pin   (ext_clk_pin),
		.level (ext_lvl),
		.rise  (ext_rise_unused),
		.fall  (ext_fall_unused)
	);
	// apb decode; access is taken in the first cycle penable is high, pready follows one cycle later
	wire acc = psel & penable & ~pready;
	wire wr  = acc & pwrite;
	wire rd  = acc & ~pwrite;
	wire wr_cnt  = wr && paddr == `FRT_A_CNT;
	wire wr_cmpa = wr && paddr == `FRT_A_CMPA;
	wire wr_cmpb = wr && paddr == `FRT_A_CMPB;
	wire [1:0] cks = timer_control_reg[`FRT_C_CKS_LO +: 2];
	wire buf_a = timer_control_reg[`FRT_C_BUFA];
	wire buf_b = timer_control_reg[`FRT_C_BUFB];
	// count source: a mux of divided clocks; a switch that drops the
	// selected level looks like a falling edge and counts
	reg src_int;
	always @* begin
		case (cks) // [RQ18]
			`FRT_CKS_D2:  src_int = prescale[`FRT_TAP_D2];
			`FRT_CKS_D8:  src_int = prescale[`FRT_TAP_D8];
			`FRT_CKS_D32: src_int = prescale[`FRT_TAP_D32];
			default:      src_int = 1'b0;
		endcase
	end
	// int_prev and ext_prev keep running across switches on purpose
	wire use_ext = cks == `FRT_CKS_EXT;
	wire src_now = use_ext ? ext_lvl : ~src_int; // [RQ15] [RQ16]
	wire src_prv = use_ext ? ext_prev : ~int_prev;
	wire tick = src_now & ~src_prv;
	// compare match: last state of equality, when the next tick moves away
	wire eq_a = free_running_counter == compare_reg_a;
	wire eq_b = free_running_counter == compare_reg_b;
	wire match_a = tick & eq_a & ~wr_cmpa; // [RQ7] [RQ14]
	wire match_b = tick & eq_b & ~wr_cmpb; // [RQ7] [RQ14]
	wire clr_a = match_a & timer_status_control_reg[`FRT_S_CLRA]; // [RQ20]
	// captures; a read of the whole capture word counts as high byte read
	wire rd_a = rd && paddr == `FRT_A_CAPA;
	wire rd_b = rd && paddr == `FRT_A_CAPB;
	wire rd_c = rd && paddr == `FRT_A_CAPC;
	wire rd_d = rd && paddr == `FRT_A_CAPD;
	wire [3:0] cap_edge;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_edge
			assign cap_edge[g] = timer_control_reg[`FRT_C_EDGE_LO + g] ?
				cap_rise[g] : cap_fall[g]; // [RQ1]
		end
	endgenerate
	wire [3:0] cap_req = cap_edge | cap_pend;
	// a pair read blocks buffered channel; own read blocks plain channel
	wire [3:0] cap_busy;
	assign cap_busy[0] = buf_a ? (rd_a | rd_c) : rd_a; // [RQ2] [RQ5]
	assign cap_busy[1] = buf_b ? (rd_b | rd_d) : rd_b; // [RQ2] [RQ5]
	assign cap_busy[2] = buf_a ? (rd_a | rd_c) : rd_c; // [RQ2] [RQ5]
	assign cap_busy[3] = buf_b ? (rd_b | rd_d) : rd_d; // [RQ2] [RQ5]
	wire [3:0] cap_go = cap_req & ~cap_busy;
	// software clears a status flag by writing 0 to it; set wins
	wire wr_stat = wr && paddr == `FRT_A_STAT;
	// a clear or a counter write in the wrap cycle stops the wrap, so no flag
	wire [6:0] flag_set = {tick && ~clr_a && ~wr_cnt && free_running_counter == `FRT_CNT_MAX, // [RQ8]
		match_b, match_a, cap_go};
	wire [6:0] flag_keep = wr_stat ? pwdata[6:0] : 7'h7f;
	always @(posedge clk) begin
		if (!live) begin // [RQ9]
			free_running_counter       <= `FRT_ZERO16;
			compare_reg_a              <= `FRT_CNT_MAX;
			compare_reg_b              <= `FRT_CNT_MAX;
			capture_reg_a              <= `FRT_ZERO16;
			capture_reg_b              <= `FRT_ZERO16;
			capture_reg_c              <= `FRT_ZERO16;
			capture_reg_d              <= `FRT_ZERO16;
			timer_irq_enable_reg       <= 7'h00;
			timer_control_reg          <= 8'h00;
			compare_output_control_reg <= 2'h0;
			timer_status_control_reg   <= 8'h00;
			prescale                   <= {DIV_W{1'b0}};
			cap_pend                   <= 4'h0;
			int_prev                   <= 1'b0;
			ext_prev                   <= 1'b0;
			cmpa_hold                  <= 1'b0;
			cmpb_hold                  <= 1'b0;
			compare_out_pin_a          <= 1'b0; // [RQ19]
			compare_out_pin_b          <= 1'b0;
			timer_irq                  <= 1'b0;
			prdata                     <= 32'h00000000;
			pready                     <= 1'b0;
			pslverr                    <= 1'b0;
		end else begin
			prescale <= prescale + {{(DIV_W-1){1'b0}}, 1'b1};
			int_prev <= src_int;
			ext_prev <= ext_lvl;
			cap_pend <= cap_req & cap_busy; // [RQ2] [RQ5]
			cmpa_hold <= match_a;
			cmpb_hold <= match_b;
			// counter: clear beats write beats increment
			if (clr_a)
				free_running_counter <= `FRT_ZERO16; // [RQ12] [RQ20]
			else if (wr_cnt)
				free_running_counter <= pwdata[15:0]; // [RQ13]
			else if (tick)
				free_running_counter <= free_running_counter + 16'h0001;
			if (wr_cmpa)
				compare_reg_a <= pwdata[15:0];
			if (wr_cmpb)
				compare_reg_b <= pwdata[15:0];
			if (match_a)
				compare_out_pin_a <= compare_output_control_reg[`FRT_O_LVLA]; // [RQ19]
			if (match_b)
				compare_out_pin_b <= compare_output_control_reg[`FRT_O_LVLB]; // [RQ19]
			// captures in the same cycle as flag set
			if (cap_go[0]) begin // [RQ6]
				capture_reg_a <= free_running_counter;
				if (buf_a)
					capture_reg_c <= capture_reg_a; // [RQ3]
			end
			if (cap_go[1]) begin // [RQ6]
				capture_reg_b <= free_running_counter;
				if (buf_b)
					capture_reg_d <= capture_reg_b; // [RQ3]
			end
			// in buffer mode channel c/d pins only set their flags
			if (cap_go[2] && !buf_a)
				capture_reg_c <= free_running_counter; // [RQ4] [RQ6]
			if (cap_go[3] && !buf_b)
				capture_reg_d <= free_running_counter; // [RQ4] [RQ6]
			if (cap_go[2] && buf_a && !cap_go[0])
				capture_reg_c <= capture_reg_c; // [RQ4]
			timer_status_control_reg[6:0] <= (timer_status_control_reg[6:0] & flag_keep)
				| flag_set; // [RQ6] [RQ8] [RQ11]
			if (wr_stat)
				timer_status_control_reg[`FRT_S_CLRA] <= pwdata[`FRT_S_CLRA];
			timer_irq <= |(timer_status_control_reg[6:0] & timer_irq_enable_reg); // [RQ10] [RQ11]
			// apb: one wait state, answer in the cycle after penable rises
			pready  <= acc;
			pslverr <= 1'b0;
			if (wr) begin
				case (paddr)
					`FRT_A_IEN:  timer_irq_enable_reg <= pwdata[6:0];
					`FRT_A_CTRL: timer_control_reg <= pwdata[7:0];
					`FRT_A_OCTL: compare_output_control_reg <= pwdata[1:0];
					`FRT_A_CNT, `FRT_A_CMPA, `FRT_A_CMPB, `FRT_A_STAT: ;
					default:     pslverr <= 1'b1;
				endcase
			end
			if (rd) begin
				case (paddr)
					`FRT_A_CNT:  prdata <= {16'h0000, free_running_counter};
					`FRT_A_CMPA: prdata <= {16'h0000, compare_reg_a};
					`FRT_A_CMPB: prdata <= {16'h0000, compare_reg_b};
					`FRT_A_CAPA: prdata <= {16'h0000, capture_reg_a};
					`FRT_A_CAPB: prdata <= {16'h0000, capture_reg_b};
					`FRT_A_CAPC: prdata <= {16'h0000, capture_reg_c};
					`FRT_A_CAPD: prdata <= {16'h0000, capture_reg_d};
					`FRT_A_IEN:  prdata <= {25'h0000000, timer_irq_enable_reg};
					`FRT_A_CTRL: prdata <= {24'h000000, timer_control_reg};
					`FRT_A_OCTL: prdata <= {30'h00000000, compare_output_control_reg};
					`FRT_A_STAT: prdata <= {24'h000000, timer_status_control_reg};
					default: begin
						prdata  <= 32'h00000000;
						pslverr <= 1'b1;
					end
				endcase
			end else if (!acc) begin
				prdata <= 32'h00000000;
			end
		end
	end
endmodule

// File: verilog/frt_defs.vh
// constants for the free running capture/compare timer
// assumes inclusion by bare name from the design files
`ifndef FRT_DEFS_VH
`define FRT_DEFS_VH
// register byte addresses (word aligned, data in low 16 bits)
`define FRT_A_CNT     12'h000
`define FRT_A_CMPA    12'h004
`define FRT_A_CMPB    12'h008
`define FRT_A_CAPA    12'h00c
`define FRT_A_CAPB    12'h010
`define FRT_A_CAPC    12'h014
`define FRT_A_CAPD    12'h018
`define FRT_A_IEN     12'h01c
`define FRT_A_CTRL    12'h020
`define FRT_A_OCTL    12'h024
`define FRT_A_STAT    12'h028
// control register fields
`define FRT_C_EDGE_LO 0
`define FRT_C_BUFA    4
`define FRT_C_BUFB    5
`define FRT_C_CKS_LO  6
// output control fields
`define FRT_O_LVLA    0
`define FRT_O_LVLB    1
// status fields: capture a..d, compare a,b, wrap
`define FRT_S_CMPA    4
`define FRT_S_CMPB    5
`define FRT_S_WRAP    6
`define FRT_S_CLRA    7
// clock select codes
`define FRT_CKS_D2    2'h0
`define FRT_CKS_D8    2'h1
`define FRT_CKS_D32   2'h2
`define FRT_CKS_EXT   2'h3
// prescaler taps (bit index of divider producing div 2, 8, 32)
`define FRT_TAP_D2    0
`define FRT_TAP_D8    2
`define FRT_TAP_D32   4
`define FRT_CNT_MAX   16'hffff
`define FRT_ZERO16    16'h0000
`endif

// File: verilog/frt_sync.v
// two flop synchroniser with edge outputs for one pin
// assumes pin is asynchronous to clk
`timescale 1ns/1ns
module frt_sync (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// pin and results
	input  wire pin,
	output reg  level,
	output wire rise,
	output wire fall
);
	reg meta;
	reg sync;
	always @(posedge clk) begin
		if (!rst_n) begin
			meta  <= 1'b0;
			sync  <= 1'b0;
			level <= 1'b0;
		end else begin
			meta  <= pin;
			sync  <= meta;
			level <= sync;
		end
	end
	// edges compare second and third stage only, never the first
	assign rise = sync & ~level;
	assign fall = ~sync & level;
endmodule

// File: sim/frt_checker.sv
// port assertions for the capture/compare timer
// assumes bound onto frt_timer, one clock, sync active-low reset
`timescale 1ns/1ns
module frt_checker (
	// clock and reset
	input wire        clk,
	input wire        rst_n,
	input wire        run_mode,
	// bus
	input wire        psel,
	input wire        penable,
	input wire [11:0] paddr,
	input wire [31:0] prdata,
	input wire        pready,
	input wire        pslverr,
	// pins
	input wire        compare_out_pin_a,
	input wire        compare_out_pin_b,
	input wire        timer_irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	a_unmapped_err: assert property (psel && penable && !pready && paddr > 12'h028 |=> pslverr)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && !pready && paddr <= 12'h028 |=> !pslverr)
		else $error("mapped access refused");
	a_mode_reset: assert property (!run_mode |=> !timer_irq)
		else $error("request survives power mode reset");
	a_mode_pins: assert property (!run_mode [*2] |-> !compare_out_pin_a && !compare_out_pin_b)
		else $error("outputs not zero in power mode reset");
	cover property (pslverr);
	cover property ($rose(compare_out_pin_a));
	cover property ($rose(timer_irq));
endmodule

// File: sim/frt_cpu.sv
// apb master in the cpu's place, noting expected read answers
// assumes testbench holds err_total and test_done
`timescale 1ns/1ns
module frt_cpu (
	// clock
	input  wire        clk,
	// apb
	output reg         psel,
	output reg         penable,
	output reg         pwrite,
	output reg  [11:0] paddr,
	output reg  [31:0] pwdata,
	input  wire        pready
);
	logic [32:0] exp_q[$];
	initial begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
	end
	// whole word per access: the 32-bit bus needs no byte latch
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		psel <= 0;
		penable <= 0;
		if (n == 20) begin
			testbench.err_total++;
			testbench.test_done();
		end
	endtask
	task rd(input logic [11:0] a, input logic [32:0] e);
		exp_q.push_back(e);
		xfer(0, a, 0);
	endtask
endmodule

// File: sim/testbench.sv
// self-checking bench for frt_timer driven through frt_cpu
// assumes the external clock pin gives a frozen, steppable counter
`timescale 1ns/1ns
module testbench;
	logic        clk, rst_n, run_mode, ext_clk_pin;
	logic [3:0]  capture_pin;
	logic [15:0] v;
	logic [32:0] e;
	wire         psel, penable, pwrite, pready, pslverr, out_a, out_b, timer_irq;
	wire  [11:0] paddr;
	wire  [31:0] pwdata, prdata;
	int          err_total, compares;
	frt_cpu cpu (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready));
	frt_timer uut (.clk(clk), .rst_n(rst_n), .run_mode(run_mode), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
		.ext_clk_pin(ext_clk_pin), .compare_out_pin_a(out_a), .compare_out_pin_b(out_b),
		.timer_irq(timer_irq));
	task chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task test_done;
		$display("err_total=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		cpu.xfer(1, a, d);
	endtask
	task tick;
		ext_clk_pin <= 1;
		repeat (3) @(posedge clk);
		ext_clk_pin <= 0;
		repeat (3) @(posedge clk);
	endtask
	// read answers are compared against the oldest note
	always @(posedge clk) begin
		if (pready === 1'b1 && pwrite === 1'b0) begin
			e = (cpu.exp_q.size() > 0) ? cpu.exp_q.pop_front() : 33'h1_dead_beef;
			chk({pslverr, prdata}, e);
		end
	end
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst_n = 0;
		run_mode = 1;
		ext_clk_pin = 0;
		capture_pin = 4'h0;
		void'($urandom(74));
		repeat (8) @(posedge clk);
		rst_n <= 1;
		cpu.rd(12'h004, 33'h0_0000_ffff);
		cpu.rd(12'h020, 33'h0);
		cpu.rd(12'h028, 33'h0);
		cpu.rd(12'h02c, 33'h1_0000_0000);
		wr(12'h020, 32'h0000_00c1);
		v = $urandom;
		wr(12'h000, {16'h0, v});
		capture_pin[0] <= 1;
		repeat (6) @(posedge clk);
		cpu.rd(12'h00c, {17'h0, v});
		capture_pin[1] <= 1;
		repeat (6) @(posedge clk);
		cpu.rd(12'h028, 33'h1);
		capture_pin[1] <= 0;
		repeat (6) @(posedge clk);
		cpu.rd(12'h010, {17'h0, v});
		cpu.rd(12'h028, 33'h3);
		wr(12'h028, 32'h80);
		wr(12'h01c, 32'h10);
		wr(12'h024, 32'h1);
		wr(12'h004, 32'h5);
		wr(12'h000, 32'h4);
		tick();
		chk(out_a, 0);
		tick();
		chk(out_a, 1);
		chk(timer_irq, 1);
		cpu.rd(12'h000, 33'h0);
		cpu.rd(12'h028, 33'h90);
		// software inverts the level after the match, as for a 50% pulse
		wr(12'h024, 32'h0);
		wr(12'h000, 32'h5);
		tick();
		chk(out_a, 0);
		cpu.rd(12'h000, 33'h0);
		wr(12'h028, 32'h0);
		repeat (3) @(posedge clk);
		chk(timer_irq, 0);
		wr(12'h000, 32'hffff);
		tick();
		cpu.rd(12'h000, 33'h0);
		cpu.rd(12'h028, 33'h60);
		run_mode <= 0;
		repeat (2) @(posedge clk);
		run_mode <= 1;
		chk(out_a, 0);
		cpu.rd(12'h004, 33'h0_0000_ffff);
		cpu.rd(12'h028, 33'h0);
		v = $urandom;
		wr(12'h008, {16'h0, v});
		cpu.rd(12'h008, {17'h0, v});
		repeat (4) @(posedge clk);
		test_done();
	end
endmodule
bind frt_timer frt_checker chk_i (.clk(clk), .rst_n(rst_n), .run_mode(run_mode), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.compare_out_pin_a(compare_out_pin_a), .compare_out_pin_b(compare_out_pin_b),
	.timer_irq(timer_irq));
